// file: bench/usb_device_link_core_tb.sv
// Purpose: Self-checking bench for the USB device link core
// Assumes: Shortened chirp and idle counts
// Notes:   Expectations come from the bench itself
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module usb_device_link_core_tb;
    import usb_link_pkg::*;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic vbus_sense = 0, line_se0, host_chirp, rx_activity, usb_wr_ready;
    logic usb_wr_valid = 0, usb_wr_last = 0, do_reset = 0, hs_host = 0, sof_en = 1, se0_req = 0;
    logic [15:0] usb_wr_data = 16'h0, w0, w1, usb_rd_data;
    logic usb_rd_req = 0, resume_seen = 0, usb_rd_valid, usb_rd_last, suspend_out, srp_pulse;
    logic [3:0] usb_rd_ep = 4'h0, usb_wr_ep = 4'h0;
    logic pullup_pin, hs_term_en, chirp_drive, speed_hs, dma_start;
    logic [1:0] dma_opcode, op;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    usb_link_core #(.IDLE_CYCLES(50), .CHIRP_CYCLES(20)) dut (
        .clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .vbus_sense, .line_se0, .host_chirp, .rx_activity, .resume_seen,
        .usb_addr(7'h00), .usb_wr_valid, .usb_wr_setup(1'b0), .usb_wr_last, .usb_wr_ep,
        .usb_wr_data, .usb_wr_ready, .usb_rd_req, .usb_rd_ep, .usb_rd_data,
        .usb_rd_valid, .usb_rd_last, .pullup_pin, .hs_term_en, .chirp_drive, .speed_hs,
        .suspend_out, .srp_pulse, .dma_start, .dma_opcode);
    usb_host_model host (.clock, .srst, .do_reset, .hs_host, .sof_en, .se0_req,
        .chirp_drive, .line_se0, .host_chirp, .rx_activity);
    initial forever #50 clock = ~clock;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic usbw(input logic [15:0] d, input logic last);
        @(posedge clock);
        usb_wr_valid <= 1'b1; usb_wr_data <= d; usb_wr_last <= last;
        @(posedge clock);
        while (usb_wr_ready !== 1'b1) @(posedge clock);
        usb_wr_valid <= 1'b0;
    endtask : usbw
    // Bounded wait; the outer cycle ceiling catches the rest
    task automatic wait_lvl(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(posedge clock);
        #1;
    endtask : wait_lvl
    task automatic bus_reset(input logic hs);
        @(posedge clock);
        hs_host <= hs; do_reset <= 1'b1;
        @(posedge clock);
        do_reset <= 1'b0;
        wait_lvl(chirp_drive, 1'b1, 1200);
        `CHK("chirp", 1'b1, chirp_drive)
        `CHK("chirp_pullup", 1'b1, pullup_pin)
        `CHK("chirp_term", 1'b0, hs_term_en)
    endtask : bus_reset
    task tally_and_finish;
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        op = 2'($urandom(32'h78DB));
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        apb(0, OFS_MODE, 0, rd, err);
        `CHK("mode_rst", 32'h0, rd)
        `CHK("pullup_rst", 1'b0, pullup_pin)
        apb(0, 8'h3C, 0, rd, err);
        `CHK("unmapped", 1'b1, err)
        vbus_sense <= 1'b1;
        apb(1, OFS_MODE, 32'h1, rd, err);
        #1 `CHK("pullup_on", 1'b1, pullup_pin)
        @(posedge clock) vbus_sense <= 1'b0;
        #1 `CHK("pullup_novbus", 1'b0, pullup_pin)
        apb(1, OFS_MODE, 0, rd, err);
        vbus_sense <= 1'b1;
        apb(1, OFS_MODE, 32'h3, rd, err);
        #1 `CHK("srp", 1'b1, srp_pulse)
        apb(0, OFS_STATUS, 0, rd, err);
        `CHK("state_fs", ST_FS, rd[2:0])
        w0 = 16'($urandom); w1 = 16'($urandom);
        usbw(w0, 1'b0);
        usbw(w1, 1'b1);
        #1 `CHK("out_full", 1'b0, usb_wr_ready)
        apb(0, OFS_BUF, 0, rd, err);
        `CHK("buf_w0", {16'h0, w0}, rd)
        #1 `CHK("held", 1'b0, usb_wr_ready)
        apb(0, OFS_BUF, 0, rd, err);
        `CHK("buf_w1", {16'h0, w1}, rd)
        #1 `CHK("released", 1'b1, usb_wr_ready)
        usbw(w1, 1'b1);
        apb(1, OFS_CTRL_FN, 32'h1, rd, err);
        #1 `CHK("cleared", 1'b1, usb_wr_ready)
        apb(1, OFS_EP_SEL, 32'h3, rd, err);
        apb(1, OFS_EP_CFG, 32'h81, rd, err);
        apb(1, OFS_BUF, {16'h0, w0}, rd, err);
        apb(1, OFS_BUF, {16'h0, w1}, rd, err);
        apb(1, OFS_CTRL_FN, 32'h2, rd, err);
        usb_rd_ep <= 4'h3;
        @(posedge clock) usb_rd_req <= 1'b1;
        @(posedge clock) usb_rd_req <= 1'b0;
        #1 `CHK("in_w0", {2'b10, w0}, {usb_rd_valid, usb_rd_last, usb_rd_data})
        @(posedge clock) usb_rd_req <= 1'b1;
        @(posedge clock) usb_rd_req <= 1'b0;
        #1 `CHK("in_w1", {2'b11, w1}, {usb_rd_valid, usb_rd_last, usb_rd_data})
        bus_reset(1'b1);
        wait_lvl(speed_hs, 1'b1, 100);
        `CHK("hs", 1'b1, speed_hs)
        apb(0, OFS_MODE, 0, rd, err);
        `CHK("mode_kept", 1'b1, rd[0])
        repeat (200) @(posedge clock);
        `CHK("hs_sof", 1'b1, speed_hs)
        sof_en <= 1'b0;
        repeat (40) @(posedge clock);
        `CHK("hs_idle", 1'b1, speed_hs)
        se0_req <= 1'b1;
        wait_lvl(speed_hs, 1'b0, 20);
        `CHK("fallback", 1'b0, speed_hs)
        wait_lvl(chirp_drive, 1'b1, 1300);
        `CHK("rechirp", 1'b1, chirp_drive)
        @(posedge clock) se0_req <= 1'b0;
        sof_en <= 1'b1;
        wait_lvl(speed_hs, 1'b1, 100);
        `CHK("hs_again", 1'b1, speed_hs)
        bus_reset(1'b0);
        repeat (60) @(posedge clock);
        apb(0, OFS_STATUS, 0, rd, err);
        `CHK("fs_host", ST_FS, rd[2:0])
        sof_en <= 1'b0;
        wait_lvl(suspend_out, 1'b1, 100);
        @(posedge clock) resume_seen <= 1'b1;
        @(posedge clock) resume_seen <= 1'b0;
        apb(1, OFS_MODE, 0, rd, err);
        #1 `CHK("locked", 2'b11, {err, pullup_pin})
        apb(1, OFS_UNLOCK, {16'h0, UNLOCK_CODE}, rd, err);
        apb(1, OFS_MODE, 0, rd, err);
        #1 `CHK("unlocked", 2'b00, {err, pullup_pin})
        repeat (4) begin
            apb(1, OFS_DMA_CMD, {30'h0, op[0] ? DMA_PIO : DMA_GENERIC}, rd, err);
            #1 `CHK("dma_start", 1'b1, dma_start)
            `CHK("dma_op", op[0] ? DMA_PIO : DMA_GENERIC, dma_opcode)
            op = 2'($urandom);
        end
        tally_and_finish();
    end
endmodule : usb_device_link_core_tb

// file: bench/usb_host_model.sv
// Purpose: Behavioural host controller facing the link core
// Assumes: Bus reset and chirp answer are asked for by the bench
// Notes:   Host SE0 ends when the device chirp ends, as a real host would
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic do_reset,
    input  wire logic hs_host,
    input  wire logic sof_en,
    input  wire logic se0_req,
    input  wire logic chirp_drive,
    output logic      line_se0,
    output logic      host_chirp,
    output logic      rx_activity
);
    logic       rst_q;
    logic       drv_q;
    logic [2:0] sof_q;
    logic [2:0] kj_q;
    assign line_se0   = rst_q | se0_req;
    assign host_chirp = (kj_q != 3'h0);
    always_ff @(posedge clock) begin
        drv_q <= chirp_drive;
        sof_q <= srst ? 3'h0 : sof_q + 3'h1;
        // Microframe SOF only outside bus reset
        rx_activity <= !srst && sof_en && !rst_q && (sof_q == 3'h0);
        if (srst) begin
            rst_q <= 1'b0;
            kj_q  <= 3'h0;
        end else if (do_reset) begin
            rst_q <= 1'b1;
        end else if (drv_q && !chirp_drive) begin
            rst_q <= 1'b0;
            // A full speed host never answers the chirp
            kj_q  <= hs_host ? 3'h7 : 3'h0;
        end else if (kj_q != 3'h0) begin
            kj_q  <= kj_q - 3'h1;
        end
    end
endmodule : usb_host_model

// file: core/usb_link_core.sv
// Purpose: USB device link core: speed negotiation, pull-up, endpoint buffers, APB regs
// Assumes: All inputs synchronous to clock; line monitor supplies se0/chirp/activity
// Notes:   Even endpoint index is OUT (host to device), odd index is IN
// Notes on behaviour
// - After attach stay in full speed until a host bus reset is seen
// - During a host bus reset start a high speed chirp
// - While chirping keep pull-up connected and high speed termination off
// - Host chirp answer moves to high speed, otherwise stay full speed
// - High speed with 3 ms of silence falls back to full speed
// - SE0 lasting 100 to 875 us after fallback restarts the chirp
// - Pull-up pin drives D+ only while the pull-up connect bit is one
// - Hardware reset clears the pull-up connect bit
// - A USB bus reset leaves the pull-up connect bit alone
// - Endpoint buffer is released only after all its data is consumed
// - Clear-buffer bit empties the selected OUT endpoint buffer at once
// - One 8 kbyte buffer memory shared by USB, processor and DMA sides; here only USB and processor write it
// - Seven IN and seven OUT endpoints, each enabled and configured separately
// - Control endpoints are fixed at 64 bytes; separate setup buffer
// - Protocol engine checks address and handshakes without firmware
// - High speed path moves data over a 16-bit parallel interface
// - After resume register writes are blocked until the unlock code
// - Writing the DMA command register starts a generic or PIO transfer
// - Sampling clock is the 12 MHz reference multiplied by forty
// - Device can start a session request asking for bus power
// - Without bus power the pull-up pin is disconnected at once
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module usb_link_core
    import usb_link_pkg::*;
#(
    parameter int IDLE_CYCLES  = IDLE_CYC,
    parameter int SE0_MAX_CYCLES = SE0_MAX_CYC,
    parameter int CHIRP_CYCLES = CHIRP_CYC,
    parameter int BUF_WORDS    = BUF_BYTES / 2
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        vbus_sense,
    input  wire logic        line_se0,
    input  wire logic        host_chirp,
    input  wire logic        rx_activity,
    input  wire logic        resume_seen,
    input  wire logic [6:0]  usb_addr,
    input  wire logic        usb_wr_valid,
    input  wire logic        usb_wr_setup,
    input  wire logic        usb_wr_last,
    input  wire logic [3:0]  usb_wr_ep,
    input  wire logic [15:0] usb_wr_data,
    output logic             usb_wr_ready,
    input  wire logic        usb_rd_req,
    input  wire logic [3:0]  usb_rd_ep,
    output logic [15:0]      usb_rd_data,
    output logic             usb_rd_valid,
    output logic             usb_rd_last,
    output logic             pullup_pin,
    output logic             hs_term_en,
    output logic             chirp_drive,
    output logic             speed_hs,
    output logic             suspend_out,
    output logic             srp_pulse,
    output logic             dma_start,
    output logic [1:0]       dma_opcode
);
    localparam int REGION_W = BUF_WORDS / NUM_EP;
    localparam int PTR_W    = $clog2(REGION_W) + 1;
    localparam int ADDR_W   = $clog2(BUF_WORDS);
    localparam int EPB      = $clog2(NUM_EP);
    localparam int TMR_W    = 16;
    localparam logic [PTR_W-1:0] CTRL_WORDS = PTR_W'(CTRL_EP_BYTES / 2);

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    logic                 pullup_connect_q, srp_req_q, lock_q;
    logic [EPB-1:0]       ep_sel_q;
    logic [6:0]           dev_addr_q;
    logic [CFG_W-1:0]     ep_cfg_q [NUM_EP];
    logic [15:0]          setup_q [SETUP_WORDS];
    logic [15:0]          mem [BUF_WORDS];
    logic [PTR_W-1:0]     wr_ptr_q [NUM_EP];
    logic [PTR_W-1:0]     rd_ptr_q [NUM_EP];
    logic                 full_q [NUM_EP];
    link_state_t          state_q;
    logic [TMR_W-1:0]     timer_q;
    logic                 access, wr_acc, rd_acc, mapped, blocked;
    logic                 sel_out, sel_full;

    assign access  = psel && penable;
    assign mapped  = paddr inside {OFS_MODE, OFS_STATUS, OFS_EP_SEL, OFS_EP_CFG, OFS_CTRL_FN,
                                   OFS_BUF, OFS_EP_CNT, OFS_UNLOCK, OFS_DMA_CMD, OFS_SETUP,
                                   OFS_ADDR};
    assign blocked = pwrite && lock_q && (paddr != OFS_UNLOCK);
    assign wr_acc  = access && pwrite && mapped && !blocked;
    assign rd_acc  = access && !pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = access && (!mapped || blocked);
    assign sel_out = !ep_sel_q[0];
    assign sel_full = full_q[ep_sel_q];

    always_ff @(posedge clock) begin
        if (srst) begin
            pullup_connect_q <= 1'b0;
            srp_req_q        <= 1'b0;
            ep_sel_q         <= '0;
            dev_addr_q       <= '0;
            dma_opcode       <= DMA_GENERIC;
        end else if (wr_acc) begin
            unique case (paddr)
                OFS_MODE: begin
                    pullup_connect_q <= pwdata[MODE_PULLUP];
                    srp_req_q        <= pwdata[MODE_SRP];
                end
                OFS_EP_SEL:  ep_sel_q   <= pwdata[EPB-1:0];
                OFS_ADDR:    dev_addr_q <= pwdata[6:0];
                OFS_DMA_CMD: dma_opcode <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Per-endpoint enable, type, double-buffer flag and packet size
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < NUM_EP; i++) ep_cfg_q[i] <= '0;
        end else if (wr_acc && paddr == OFS_EP_CFG) begin
            ep_cfg_q[ep_sel_q] <= pwdata[CFG_W-1:0];
        end
    end

    // Single-cycle strobes toward DMA handler and session request logic
    always_ff @(posedge clock) begin
        if (srst) begin
            dma_start <= 1'b0;
            srp_pulse <= 1'b0;
        end else begin
            dma_start <= wr_acc && paddr == OFS_DMA_CMD;
            srp_pulse <= wr_acc && paddr == OFS_MODE && pwdata[MODE_SRP] && !srp_req_q;
        end
    end

    // Lock is taken on a resume_seen wake from suspend so a glitchy resume cannot corrupt settings
    always_ff @(posedge clock) begin
        if (srst) begin
            lock_q <= 1'b0;
        end else if (state_q == ST_SUSPEND && resume_seen) begin
            lock_q <= 1'b1;
        end else if (access && pwrite && paddr == OFS_UNLOCK
                     && pwdata[15:0] == UNLOCK_CODE) begin
            lock_q <= 1'b0;
        end
    end

    // Read data is captured in the setup phase so prdata comes from a flop
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= RESET_ZERO;
        end else if (psel && !penable) begin
            prdata <= RESET_ZERO;
            unique case (paddr)
                OFS_MODE:    prdata[1:0] <= {srp_req_q, pullup_connect_q};
                OFS_STATUS:  prdata[6:0] <= {vbus_sense, lock_q, sel_full, 1'b0, state_q};
                OFS_EP_SEL:  prdata[EPB-1:0] <= ep_sel_q;
                OFS_EP_CFG:  prdata[CFG_W-1:0] <= ep_cfg_q[ep_sel_q];
                OFS_BUF:     prdata[15:0] <= mem[ADDR_W'(ep_sel_q) * ADDR_W'(REGION_W)
                                                 + ADDR_W'(rd_ptr_q[ep_sel_q])];
                OFS_EP_CNT:  prdata[PTR_W-1:0] <= wr_ptr_q[ep_sel_q] - rd_ptr_q[ep_sel_q];
                OFS_SETUP:   prdata[15:0] <= setup_q[ep_sel_q[1:0]];
                OFS_ADDR:    prdata[6:0] <= dev_addr_q;
                OFS_DMA_CMD: prdata[1:0] <= dma_opcode;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Speed negotiation
    // ----------------------------------------
    link_state_t state_d;
    logic        tmr_clr, se0_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_FS: begin
                if (line_se0 && timer_q >= TMR_W'(RST_DET_CYC - 1)) state_d = ST_CHIRP;
                else if (!line_se0 && timer_q >= TMR_W'(IDLE_CYCLES - 1)) state_d = ST_SUSPEND;
            end
            ST_CHIRP: begin
                if (host_chirp && timer_q >= TMR_W'(CHIRP_CYCLES)) state_d = ST_HS;
                else if (timer_q >= TMR_W'(2 * CHIRP_CYCLES)) state_d = ST_FS;
            end
            ST_HS: begin
                if (!rx_activity && timer_q >= TMR_W'(IDLE_CYCLES - 1)) state_d = ST_FALLBACK;
            end
            ST_FALLBACK: begin
                if (!line_se0) state_d = ST_FS;
                else if (timer_q >= TMR_W'(SE0_MIN_CYC - 1)
                         && timer_q < TMR_W'(SE0_MAX_CYCLES)) state_d = ST_CHIRP;
            end
            ST_SUSPEND: begin
                if (resume_seen || line_se0 || rx_activity) state_d = ST_FS;
            end
            default: state_d = ST_FS;
        endcase
    end

    // FS timer restarts whenever the SE0 level flips so it measures one run;
    // activity is ignored while chirping, where the timer paces the chirp
    assign tmr_clr = (state_d != state_q) || (rx_activity && state_q != ST_CHIRP)
                     || (state_q == ST_FS && line_se0 != se0_q);

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_FS;
            timer_q <= '0;
            se0_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            se0_q   <= line_se0;
            if (tmr_clr || (state_q == ST_FS && !line_se0 && rx_activity)) timer_q <= '0;
            else if (timer_q != '1) timer_q <= timer_q + 1'b1;
        end
    end

    assign pullup_pin  = pullup_connect_q && vbus_sense;
    assign hs_term_en  = (state_q == ST_HS);
    assign chirp_drive = (state_q == ST_CHIRP) && (timer_q < TMR_W'(CHIRP_CYCLES));
    assign speed_hs    = (state_q == ST_HS);
    assign suspend_out = (state_q == ST_SUSPEND);

    // ----------------------------------------
    // Endpoint buffer memory
    // ----------------------------------------
    logic             usb_hit, usb_wr_ok, usb_rd_ok, cpu_wr_ok, cpu_rd_ok, clr_ok, val_ok;
    logic [PTR_W-1:0] wcap;

    function automatic logic [PTR_W-1:0] ep_cap(input logic [EPB-1:0] ep);
        if (ep < EPB'(2)) return CTRL_WORDS;
        return PTR_W'(ep_cfg_q[ep][CFG_W-1:CFG_SIZE_LSB] >> 1);
    endfunction : ep_cap

    function automatic logic ep_on(input logic [EPB-1:0] ep);
        return (ep < EPB'(2)) || ep_cfg_q[ep][CFG_EN];
    endfunction : ep_on

    assign usb_hit   = (usb_addr == dev_addr_q) && state_q != ST_SUSPEND;
    assign wcap      = ep_cap(usb_wr_ep);
    assign usb_wr_ready = usb_hit && !usb_wr_ep[0] && ep_on(usb_wr_ep) && !full_q[usb_wr_ep]
                          && wr_ptr_q[usb_wr_ep] < wcap;
    assign usb_wr_ok = usb_wr_valid && usb_wr_ready && !usb_wr_setup;
    assign usb_rd_ok = usb_rd_req && usb_hit && usb_rd_ep[0] && full_q[usb_rd_ep];
    assign cpu_wr_ok = wr_acc && paddr == OFS_BUF && !sel_out && !sel_full
                       && ep_on(ep_sel_q) && wr_ptr_q[ep_sel_q] < ep_cap(ep_sel_q);
    assign cpu_rd_ok = rd_acc && paddr == OFS_BUF && sel_out && sel_full;
    assign clr_ok    = wr_acc && paddr == OFS_CTRL_FN && pwdata[CFN_CLEAR] && sel_out;
    assign val_ok    = wr_acc && paddr == OFS_CTRL_FN && pwdata[CFN_VALIDATE] && !sel_out;

    // Shared storage: USB fills OUT, processor fills IN
    always_ff @(posedge clock) begin
        if (usb_wr_ok)
            mem[ADDR_W'(usb_wr_ep) * ADDR_W'(REGION_W) + ADDR_W'(wr_ptr_q[usb_wr_ep])]
                <= usb_wr_data;
        if (cpu_wr_ok)
            mem[ADDR_W'(ep_sel_q) * ADDR_W'(REGION_W) + ADDR_W'(wr_ptr_q[ep_sel_q])]
                <= pwdata[15:0];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < SETUP_WORDS; i++) setup_q[i] <= '0;
        end else if (usb_wr_valid && usb_wr_setup && usb_hit && usb_wr_ep == '0) begin
            setup_q[wr_ptr_q[0][1:0]] <= usb_wr_data;
        end
    end

    // Full and empty never overlap per endpoint, so the two sides touch
    // different entries in any one cycle; clear is applied last and wins
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < NUM_EP; i++) begin
                wr_ptr_q[i] <= '0;
                rd_ptr_q[i] <= '0;
                full_q[i]   <= 1'b0;
            end
        end else begin
            if (usb_wr_ok) begin
                wr_ptr_q[usb_wr_ep] <= wr_ptr_q[usb_wr_ep] + 1'b1;
                if (usb_wr_last) full_q[usb_wr_ep] <= 1'b1;
            end
            if (cpu_wr_ok) wr_ptr_q[ep_sel_q] <= wr_ptr_q[ep_sel_q] + 1'b1;
            if (val_ok && wr_ptr_q[ep_sel_q] != '0) full_q[ep_sel_q] <= 1'b1;
            if (usb_rd_ok) begin
                if (rd_ptr_q[usb_rd_ep] + 1'b1 == wr_ptr_q[usb_rd_ep]) begin
                    rd_ptr_q[usb_rd_ep] <= '0;
                    wr_ptr_q[usb_rd_ep] <= '0;
                    full_q[usb_rd_ep]   <= 1'b0;
                end else begin
                    rd_ptr_q[usb_rd_ep] <= rd_ptr_q[usb_rd_ep] + 1'b1;
                end
            end
            if (cpu_rd_ok) begin
                if (rd_ptr_q[ep_sel_q] + 1'b1 == wr_ptr_q[ep_sel_q]) begin
                    rd_ptr_q[ep_sel_q] <= '0;
                    wr_ptr_q[ep_sel_q] <= '0;
                    full_q[ep_sel_q]   <= 1'b0;
                end else begin
                    rd_ptr_q[ep_sel_q] <= rd_ptr_q[ep_sel_q] + 1'b1;
                end
            end
            if (clr_ok) begin
                rd_ptr_q[ep_sel_q] <= '0;
                wr_ptr_q[ep_sel_q] <= '0;
                full_q[ep_sel_q]   <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            usb_rd_data  <= '0;
            usb_rd_valid <= 1'b0;
            usb_rd_last  <= 1'b0;
        end else begin
            usb_rd_valid <= usb_rd_ok;
            usb_rd_last  <= usb_rd_ok && (rd_ptr_q[usb_rd_ep] + 1'b1 == wr_ptr_q[usb_rd_ep]);
            if (usb_rd_ok)
                usb_rd_data <= mem[ADDR_W'(usb_rd_ep) * ADDR_W'(REGION_W)
                                   + ADDR_W'(rd_ptr_q[usb_rd_ep])];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_pullup_gated: assert property (pullup_pin |-> pullup_connect_q && vbus_sense)
        else $error("pull-up driven without connect bit or bus power");
    a_vbus_drop: assert property (!vbus_sense |-> !pullup_pin)
        else $error("pull-up still connected without bus power");
    a_reset_clear: assert property (@(posedge clock) disable iff (1'b0)
        srst |=> !pullup_connect_q)
        else $error("pull-up connect bit survived hardware reset");
    a_bus_reset_keep: assert property (state_q == ST_FS ##1 state_q == ST_CHIRP
        |-> $stable(pullup_connect_q))
        else $error("bus reset changed the pull-up connect bit");
    a_chirp_term: assert property (state_q == ST_CHIRP |-> !hs_term_en)
        else $error("termination enabled while chirping");
    a_fs_exit: assert property (state_q == ST_FS ##1 state_q == ST_CHIRP
        |-> $past(line_se0))
        else $error("full speed left without bus reset");
    a_hs_entry: assert property ($rose(speed_hs) |-> $past(host_chirp)
        && $past(state_q) == ST_CHIRP)
        else $error("high speed entered without host chirp");
    a_hs_idle: assert property (state_q == ST_HS && !rx_activity
        && timer_q == TMR_W'(IDLE_CYCLES - 1) |=> state_q == ST_FALLBACK)
        else $error("no fallback after high speed idle time");
    a_activity_hold: assert property (state_q == ST_HS && rx_activity |=> state_q == ST_HS
        && timer_q == '0)
        else $error("activity did not restart idle timer");
    a_fallback_chirp: assert property (state_q == ST_FALLBACK ##1 state_q == ST_CHIRP
        |-> $past(timer_q) >= TMR_W'(SE0_MIN_CYC - 1))
        else $error("chirp restarted before minimum SE0 time");
    a_lock_write: assert property (lock_q && access && pwrite && paddr == OFS_MODE
        |-> pslverr ##1 $stable(pullup_connect_q))
        else $error("locked register write took effect");
    a_clear_empty: assert property (clr_ok |=> !full_q[$past(ep_sel_q)]
        && wr_ptr_q[$past(ep_sel_q)] == '0)
        else $error("clear did not empty the out buffer");
    a_dma_go: assert property (wr_acc && paddr == OFS_DMA_CMD |=> dma_start ##1 !dma_start)
        else $error("dma command write gave no single start strobe");

    c_reach_hs: cover property (state_q == ST_CHIRP ##1 state_q == ST_HS);
    c_redetect: cover property (state_q == ST_FALLBACK ##1 state_q == ST_CHIRP);
    c_unlock: cover property (lock_q ##1 !lock_q);
    c_release: cover property (full_q[1] ##1 !full_q[1]);
endmodule : usb_link_core

// file: core/usb_link_pkg.sv
// Purpose: Shared constants for the USB device link core
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes:   Byte offsets are word aligned; times are kept in their printed units
package usb_link_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_HZ       = 10_000_000;
    localparam int IDLE_MS      = 3;
    localparam int SE0_MIN_US   = 100;
    localparam int SE0_MAX_US   = 875;
    localparam int CHIRP_US     = 1000;
    localparam int RST_DET_NS   = 2500;
    localparam int IDLE_CYC     = IDLE_MS * (CLK_HZ / 1000);
    localparam int SE0_MIN_CYC  = (SE0_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int SE0_MAX_CYC  = SE0_MAX_US * (CLK_HZ / 1000) / 1000;
    localparam int CHIRP_CYC    = CHIRP_US * (CLK_HZ / 1000) / 1000;
    localparam int RST_DET_CYC  = (RST_DET_NS / 100 + 1 > 1) ? (RST_DET_NS + 99) / 100 : 1;
    localparam int REF_MHZ      = 12;
    localparam int PLL_MULT     = 40;
    localparam int SAMPLE_MHZ   = REF_MHZ * PLL_MULT;
    // ----------------------------------------
    // Buffer memory
    // ----------------------------------------
    localparam int BUF_BYTES    = 8192;
    localparam int NUM_EP       = 16;
    localparam int CTRL_EP_BYTES = 64;
    localparam int SETUP_WORDS  = 4;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_EP_SEL  = 8'h08;
    localparam logic [7:0] OFS_EP_CFG  = 8'h0C;
    localparam logic [7:0] OFS_CTRL_FN = 8'h10;
    localparam logic [7:0] OFS_BUF     = 8'h14;
    localparam logic [7:0] OFS_EP_CNT  = 8'h18;
    localparam logic [7:0] OFS_UNLOCK  = 8'h1C;
    localparam logic [7:0] OFS_DMA_CMD = 8'h20;
    localparam logic [7:0] OFS_SETUP   = 8'h24;
    localparam logic [7:0] OFS_ADDR    = 8'h28;
    // ----------------------------------------
    // Fields and values
    // ----------------------------------------
    localparam int MODE_PULLUP  = 0;
    localparam int MODE_SRP     = 1;
    localparam int CFN_CLEAR    = 0;
    localparam int CFN_VALIDATE = 1;
    localparam int CFG_EN       = 0;
    localparam int CFG_SIZE_LSB = 4;
    localparam int CFG_W        = 15;
    localparam logic [15:0] UNLOCK_CODE = 16'hAA37;
    localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_FS       = 3'b000,
        ST_CHIRP    = 3'b001,
        ST_HS       = 3'b010,
        ST_FALLBACK = 3'b011,
        ST_SUSPEND  = 3'b100
    } link_state_t;
    typedef enum logic [1:0] {
        DMA_GENERIC = 2'b00,
        DMA_PIO     = 2'b01
    } dma_op_t;
endpackage : usb_link_pkg
